// >>> logic/ppid_params.svh
// Constants for the paged port and identification registers and their link controller.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef PPID_PARAMS_SVH
`define PPID_PARAMS_SVH

`define PPID_CLK_MHZ 200
`define PPID_FILT_NS 1000
`define PPID_FILT_CYCLES ((`PPID_FILT_NS * `PPID_CLK_MHZ + 999) / 1000)

`define PPID_ADDR_EVENT 4'h5
`define PPID_ADDR_SELECT 4'h7
`define PPID_WIN_STAT0 4'h8
`define PPID_WIN_STAT1 4'h9
`define PPID_WIN_COMPL 4'h8
`define PPID_WIN_MAKER_HI 4'hA
`define PPID_WIN_MAKER_MID 4'hB
`define PPID_WIN_MAKER_LO 4'hC
`define PPID_WIN_PROD_HI 4'hD
`define PPID_WIN_PROD_MID 4'hE
`define PPID_WIN_PROD_LO 4'hF
`define PPID_WIN_BIT 3

`define PPID_PAGE_PORT 3'h0
`define PPID_PAGE_IDENT 3'h1
`define PPID_PAGE_TEST 3'h7
`define PPID_PAGE_LSB 5
`define PPID_PORT_LSB 0

`define PPID_BIT_DISABLE 7
`define PPID_BIT_FAULT 4
`define PPID_BIT_ENABLE 3
`define PPID_BIT_EVENT 2

`define PPID_COMPLIANCE 8'h01
`define PPID_RST_PAGE 3'h0
`define PPID_RST_PORT 4'h0

`define PPID_AXI_CMD 32'h0000_0000
`define PPID_AXI_STATUS 32'h0000_0004
`define PPID_AXI_ADDR_MASK 32'h0000_00FC
`define PPID_RESP_OKAY 2'h0
`define PPID_RESP_SLVERR 2'h2

`endif

// >>> logic/ppid_pkg.sv
// Types shared by the two ends of the PHY register link.
// Assumes nothing of its surroundings.
package ppid_pkg;

  typedef logic [7:0] ppid_byte_type;
  typedef logic [3:0] ppid_addr_type;

  typedef enum logic [2:0] {
    PPID_IDLE = 3'b001,
    PPID_REQ = 3'b010,
    PPID_WAIT = 3'b100
  } ppid_state_type;

endpackage

// >>> logic/ppid_link_if.sv
// Register access link between the link controller and the PHY register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ppid_link_if;
  logic req;
  logic wr;
  ppid_pkg::ppid_addr_type addr;
  ppid_pkg::ppid_byte_type wdata;
  logic ack;
  ppid_pkg::ppid_byte_type rdata;

  modport phy (
    input req,
    input wr,
    input addr,
    input wdata,
    output ack,
    output rdata
  );

  modport link (
    output req,
    output wr,
    output addr,
    output wdata,
    input ack,
    input rdata
  );
endinterface

// >>> logic/ppid_phy_end.sv
// PHY end: selector register, port status page, identification page and port event flag.
// Assumes line status inputs are synchronous to SYS_CLK_IN and the link obeys page rules.
`timescale 1ns/1ps
`include "ppid_params.svh"

module ppid_phy_end #(
  parameter int NUM_PORTS = 3,
  parameter int FILT_CYCLES = `PPID_FILT_CYCLES,
  // Arbitrary value.
  parameter logic [23:0] MAKER_ID = 24'h12_3456,
  // Arbitrary value.
  parameter logic [23:0] PRODUCT_IDENTIFIER = 24'h00_AB01
) (
  // Clock and reset.
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  // Register link from the link controller.
  ppid_link_if.phy LINK_IF,
  // Per-port status from the cable circuits.
  input wire logic [2*NUM_PORTS-1:0] TPA_STATE_IN,
  input wire logic [2*NUM_PORTS-1:0] TPB_STATE_IN,
  input wire logic [NUM_PORTS-1:0] CHILD_IN,
  input wire logic CHILD_VALID_IN,
  input wire logic [NUM_PORTS-1:0] CONN_RAW_IN,
  input wire logic [NUM_PORTS-1:0] BIAS_RAW_IN,
  input wire logic [3*NUM_PORTS-1:0] SPEED_IN,
  input wire logic [NUM_PORTS-1:0] FAULT_SET_IN,
  input wire logic [NUM_PORTS-1:0] DISABLE_STRAP_IN,
  // Port control and status outputs.
  output logic [NUM_PORTS-1:0] PORT_DISABLE_OUT,
  output logic [NUM_PORTS-1:0] PORT_CONN_OUT,
  output logic PORT_EVENT_OUT
);
  import ppid_pkg::*;

  localparam int CW = $clog2(FILT_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYCLES - 1);

  logic [2:0] page_r;
  logic [3:0] port_sel_r;
  logic [NUM_PORTS-1:0] dis_r;
  logic [NUM_PORTS-1:0] en_r;
  logic [NUM_PORTS-1:0] fault_r;
  logic [NUM_PORTS-1:0] conn_r;
  logic [NUM_PORTS-1:0] bias_r;
  logic [NUM_PORTS-1:0] dis_d_r;
  logic [NUM_PORTS-1:0] fault_d_r;
  logic [NUM_PORTS-1:0] conn_d_r;
  logic [NUM_PORTS-1:0] bias_d_r;
  logic [CW-1:0] conn_cnt_r [NUM_PORTS];
  logic [CW-1:0] bias_cnt_r [NUM_PORTS];
  logic strap_done_r;
  logic event_r;
  logic [NUM_PORTS-1:0] port_hot;
  logic [NUM_PORTS-1:0] changed;
  ppid_byte_type stat0;
  ppid_byte_type stat1;
  logic wr_select;
  logic wr_stat0;
  logic wr_stat1;
  logic wr_event;

  // Matches a write request to one register address.
  function automatic logic wr_hit(input logic req, input logic wr, input ppid_addr_type a,
                                  input ppid_addr_type want);
    wr_hit = req && wr && (a == want);
  endfunction

  // Read data for any address, window contents chosen by the page.
  function automatic ppid_byte_type reg_read(input logic [2:0] page, input ppid_addr_type a,
                                             input ppid_byte_type s0, input ppid_byte_type s1,
                                             input logic [3:0] port, input logic evt);
    reg_read = 8'h00;
    if (a == `PPID_ADDR_SELECT) begin
      reg_read = {page, 1'b0, port};
    end else if (a == `PPID_ADDR_EVENT) begin
      reg_read[`PPID_BIT_EVENT] = evt;
    end else if (a[`PPID_WIN_BIT]) begin
      case (page)
        `PPID_PAGE_PORT: begin
          if (a == `PPID_WIN_STAT0) begin
            reg_read = s0;
          end else if (a == `PPID_WIN_STAT1) begin
            reg_read = s1;
          end
        end
        `PPID_PAGE_IDENT: begin
          case (a)
            `PPID_WIN_COMPL: reg_read = `PPID_COMPLIANCE;
            `PPID_WIN_MAKER_HI: reg_read = MAKER_ID[23:16];
            `PPID_WIN_MAKER_MID: reg_read = MAKER_ID[15:8];
            `PPID_WIN_MAKER_LO: reg_read = MAKER_ID[7:0];
            `PPID_WIN_PROD_HI: reg_read = PRODUCT_IDENTIFIER[23:16];
            `PPID_WIN_PROD_MID: reg_read = PRODUCT_IDENTIFIER[15:8];
            `PPID_WIN_PROD_LO: reg_read = PRODUCT_IDENTIFIER[7:0];
            default: reg_read = 8'h00;
          endcase
        end
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // Builds the status bytes of the port named by the port selector.
  always_comb begin
    port_hot = '0;
    stat0 = 8'h00;
    stat1 = 8'h00;
    for (int i = 0; i < NUM_PORTS; i++) begin
      port_hot[i] = (port_sel_r == 4'(i));
      if (port_hot[i]) begin
        stat0[`PPID_BIT_DISABLE] = dis_r[i];
        stat0[6] = bias_r[i];
        stat0[5] = conn_r[i];
        stat0[4] = CHILD_IN[i] & CHILD_VALID_IN;
        stat0[3:2] = TPB_STATE_IN[2*i +: 2];
        stat0[1:0] = TPA_STATE_IN[2*i +: 2];
        stat1[`PPID_BIT_FAULT] = fault_r[i];
        stat1[`PPID_BIT_ENABLE] = en_r[i];
        stat1[2:0] = SPEED_IN[3*i +: 3];
      end
    end
  end

  assign wr_select = wr_hit(LINK_IF.req, LINK_IF.wr, LINK_IF.addr, `PPID_ADDR_SELECT);
  assign wr_event = wr_hit(LINK_IF.req, LINK_IF.wr, LINK_IF.addr, `PPID_ADDR_EVENT);
  assign wr_stat0 = wr_hit(LINK_IF.req, LINK_IF.wr, LINK_IF.addr, `PPID_WIN_STAT0)
                    && (page_r == `PPID_PAGE_PORT);
  assign wr_stat1 = wr_hit(LINK_IF.req, LINK_IF.wr, LINK_IF.addr, `PPID_WIN_STAT1)
                    && (page_r == `PPID_PAGE_PORT);
  assign changed = (conn_r ^ conn_d_r) | (bias_r ^ bias_d_r) | (dis_r ^ dis_d_r)
                   | (fault_r ^ fault_d_r);

  // Page and port selector register.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      page_r <= `PPID_RST_PAGE;
      port_sel_r <= `PPID_RST_PORT;
    end else if (wr_select) begin
      page_r <= LINK_IF.wdata[`PPID_PAGE_LSB +: 3];
      port_sel_r <= LINK_IF.wdata[`PPID_PORT_LSB +: 4];
    end
  end

  // Hysteresis filters: a new level is taken only after it holds steadily.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      conn_r <= '0;
      bias_r <= '0;
      for (int i = 0; i < NUM_PORTS; i++) begin
        conn_cnt_r[i] <= '0;
        bias_cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (CONN_RAW_IN[i] == conn_r[i]) begin
          conn_cnt_r[i] <= '0;
        end else if (conn_cnt_r[i] == CNT_LAST) begin
          conn_r[i] <= CONN_RAW_IN[i];
          conn_cnt_r[i] <= '0;
        end else begin
          conn_cnt_r[i] <= conn_cnt_r[i] + 1'b1;
        end
        if (BIAS_RAW_IN[i] == bias_r[i]) begin
          bias_cnt_r[i] <= '0;
        end else if (bias_cnt_r[i] == CNT_LAST) begin
          bias_r[i] <= BIAS_RAW_IN[i];
          bias_cnt_r[i] <= '0;
        end else begin
          bias_cnt_r[i] <= bias_cnt_r[i] + 1'b1;
        end
      end
    end
  end

  // Per-port writable bits; the strap is loaded once after reset release.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      strap_done_r <= 1'b0;
      dis_r <= '0;
      en_r <= '0;
      fault_r <= '0;
    end else begin
      strap_done_r <= 1'b1;
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (!strap_done_r) begin
          dis_r[i] <= DISABLE_STRAP_IN[i];
        end else if (wr_stat0 && port_hot[i]) begin
          dis_r[i] <= LINK_IF.wdata[`PPID_BIT_DISABLE];
        end
        if (wr_stat1 && port_hot[i]) begin
          en_r[i] <= LINK_IF.wdata[`PPID_BIT_ENABLE];
        end
        if (FAULT_SET_IN[i]) begin
          fault_r[i] <= 1'b1;
        end else if (wr_stat1 && port_hot[i] && LINK_IF.wdata[`PPID_BIT_FAULT]) begin
          fault_r[i] <= 1'b0;
        end
      end
    end
  end

  // Change detection and the global port event flag.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      conn_d_r <= '0;
      bias_d_r <= '0;
      dis_d_r <= '0;
      fault_d_r <= '0;
      event_r <= 1'b0;
    end else begin
      conn_d_r <= conn_r;
      bias_d_r <= bias_r;
      dis_d_r <= dis_r;
      fault_d_r <= fault_r;
      if (|(en_r & changed & {NUM_PORTS{strap_done_r}})) begin
        event_r <= 1'b1;
      end else if (wr_event && LINK_IF.wdata[`PPID_BIT_EVENT]) begin
        event_r <= 1'b0;
      end
    end
  end

  // Answers each request one cycle later; writes read back zero.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      LINK_IF.ack <= 1'b0;
      LINK_IF.rdata <= 8'h00;
    end else begin
      LINK_IF.ack <= LINK_IF.req;
      if (LINK_IF.req && !LINK_IF.wr) begin
        LINK_IF.rdata <= reg_read(page_r, LINK_IF.addr, stat0, stat1, port_sel_r, event_r);
      end else begin
        LINK_IF.rdata <= 8'h00;
      end
    end
  end

  assign PORT_DISABLE_OUT = dis_r;
  assign PORT_CONN_OUT = conn_r;
  assign PORT_EVENT_OUT = event_r;

endmodule

// >>> logic/ppid_link_end.sv
// Link end: AXI4-Lite command and status registers driving PHY register accesses.
// Assumes the PHY end answers every request with one ack pulse on the shared clock.
`timescale 1ns/1ps
`include "ppid_params.svh"

module ppid_link_end (
  // Clock and reset.
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  // AXI4-Lite write channels.
  input wire logic [31:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  // AXI4-Lite read channels.
  input wire logic [31:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  // Register link to the PHY.
  ppid_link_if.link LINK_IF
);
  import ppid_pkg::*;

  ppid_state_type state_r;
  logic aw_have_r;
  logic w_have_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [2:0] page_shadow_r;
  logic refused_r;
  ppid_byte_type last_rdata_r;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic cmd_hit;
  logic launch;
  logic test_window;

  assign aw_take = AXI_AWVALID_IN && AXI_AWREADY_OUT;
  assign w_take = AXI_WVALID_IN && AXI_WREADY_OUT;
  assign do_write = aw_have_r && w_have_r && !AXI_BVALID_OUT;
  assign cmd_hit = do_write && ((awaddr_r & `PPID_AXI_ADDR_MASK) == `PPID_AXI_CMD);
  assign test_window = (page_shadow_r == `PPID_PAGE_TEST) && wdata_r[`PPID_WIN_BIT];
  assign launch = cmd_hit && wstrb_r[0] && (state_r == PPID_IDLE) && !test_window;

  // Write address and data capture, taken in either order, then one response.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      AXI_AWREADY_OUT <= 1'b0;
      AXI_WREADY_OUT <= 1'b0;
      AXI_BVALID_OUT <= 1'b0;
      AXI_BRESP_OUT <= `PPID_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        awaddr_r <= AXI_AWADDR_IN;
      end else if (do_write) begin
        aw_have_r <= 1'b0;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wdata_r <= AXI_WDATA_IN;
        wstrb_r <= AXI_WSTRB_IN;
      end else if (do_write) begin
        w_have_r <= 1'b0;
      end
      AXI_AWREADY_OUT <= !(aw_have_r || aw_take) || do_write;
      AXI_WREADY_OUT <= !(w_have_r || w_take) || do_write;
      if (do_write) begin
        AXI_BVALID_OUT <= 1'b1;
        AXI_BRESP_OUT <= cmd_hit ? `PPID_RESP_OKAY : `PPID_RESP_SLVERR;
      end else if (AXI_BREADY_IN) begin
        AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  // Read channel: status register; the command address reads back zero.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      AXI_ARREADY_OUT <= 1'b0;
      AXI_RVALID_OUT <= 1'b0;
      AXI_RDATA_OUT <= 32'h0000_0000;
      AXI_RRESP_OUT <= `PPID_RESP_OKAY;
    end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
      AXI_ARREADY_OUT <= 1'b0;
      AXI_RVALID_OUT <= 1'b1;
      AXI_RRESP_OUT <= `PPID_RESP_OKAY;
      AXI_RDATA_OUT <= 32'h0000_0000;
      if ((AXI_ARADDR_IN & `PPID_AXI_ADDR_MASK) == `PPID_AXI_STATUS) begin
        AXI_RDATA_OUT <= {16'h0000, last_rdata_r, 6'h00, refused_r, state_r != PPID_IDLE};
      end else if ((AXI_ARADDR_IN & `PPID_AXI_ADDR_MASK) != `PPID_AXI_CMD) begin
        AXI_RRESP_OUT <= `PPID_RESP_SLVERR;
      end
    end else if (AXI_RVALID_OUT) begin
      if (AXI_RREADY_IN) begin
        AXI_RVALID_OUT <= 1'b0;
        AXI_ARREADY_OUT <= 1'b1;
      end
    end else begin
      AXI_ARREADY_OUT <= 1'b1;
    end
  end

  // Refusal flag and the page shadow used to guard the test page.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      refused_r <= 1'b0;
      page_shadow_r <= `PPID_RST_PAGE;
    end else if (cmd_hit && wstrb_r[0]) begin
      refused_r <= (state_r != PPID_IDLE) || test_window;
      if (launch && wdata_r[16] && (wdata_r[3:0] == `PPID_ADDR_SELECT)) begin
        page_shadow_r <= wdata_r[8 + `PPID_PAGE_LSB +: 3];
      end
    end
  end

  // Link request sequencer: one pulse out, then wait for the answer.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      state_r <= PPID_IDLE;
      LINK_IF.req <= 1'b0;
      LINK_IF.wr <= 1'b0;
      LINK_IF.addr <= 4'h0;
      LINK_IF.wdata <= 8'h00;
      last_rdata_r <= 8'h00;
    end else begin
      case (state_r)
        PPID_IDLE: begin
          if (launch) begin
            LINK_IF.req <= 1'b1;
            LINK_IF.wr <= wdata_r[16];
            LINK_IF.addr <= wdata_r[3:0];
            LINK_IF.wdata <= wdata_r[15:8];
            state_r <= PPID_REQ;
          end
        end
        PPID_REQ: begin
          LINK_IF.req <= 1'b0;
          state_r <= PPID_WAIT;
        end
        PPID_WAIT: begin
          if (LINK_IF.ack) begin
            last_rdata_r <= LINK_IF.rdata;
            state_r <= PPID_IDLE;
          end
        end
        default: begin
          LINK_IF.req <= 1'b0;
          state_r <= PPID_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> tb/ppid_link_sva.sv
// Assertions on the register link between the link end and the PHY end.
// Assumes one clock and a synchronous active-low reset shared by both ends.
`timescale 1ns/1ps
module ppid_link_sva (
  // Clock and reset.
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  // Link signals.
  input wire logic req,
  input wire logic wr,
  input wire ppid_pkg::ppid_addr_type addr,
  input wire ppid_pkg::ppid_byte_type wdata,
  input wire logic ack,
  input wire ppid_pkg::ppid_byte_type rdata
);
  import ppid_pkg::*;
  logic [2:0] page_r;
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  // Page as last written over the link.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      page_r <= 3'h0;
    end else if (req && wr && addr == 4'h7) begin
      page_r <= wdata[7:5];
    end
  end
  a_ack_follows_req: assert property (req |=> ack)
    else $error("ack missing after request");
  a_ack_needs_req: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_req_spaced: assert property (req |=> !req ##1 !req)
    else $error("requests too close");
  a_idle_rdata_zero: assert property (!ack |-> rdata == 8'h00)
    else $error("read data outside ack");
  a_write_rdata_zero: assert property (ack && wr |-> rdata == 8'h00)
    else $error("read data on write");
  a_compl_level: assert property (
    ack && !wr && page_r == 3'h1 && addr == 4'h8 |-> rdata == 8'h01)
    else $error("compliance level wrong");
  a_test_page_shun: assert property (req |-> !(page_r == 3'h7 && addr[3]))
    else $error("test page accessed");
  a_rsvd_page0: assert property (
    ack && !wr && page_r == 3'h0 && addr >= 4'hA |-> rdata == 8'h00)
    else $error("reserved port address not zero");
  a_speed_code: assert property (
    ack && !wr && page_r == 3'h0 && addr == 4'h9
    |-> rdata[7:5] == 3'h0 && rdata[2:0] <= 3'h2)
    else $error("port byte two malformed");
  a_page_empty: assert property (
    ack && !wr && page_r inside {[3'h2:3'h6]} && addr[3] |-> rdata == 8'h00)
    else $error("unused page not zero");
  c_ident_read: cover property (ack && !wr && page_r == 3'h1);
  c_select_write: cover property (req && wr && addr == 4'h7);
  c_port_write: cover property (ack && wr && addr == 4'h9);
endmodule

// >>> tb/tb_phy_paged_port_id_regs.sv
// Testbench: AXI4-Lite traffic into the link end, which reaches the PHY end over the link.
// Assumes a 200 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "ppid_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, (e), (g)); end end
module tb_phy_paged_port_id_regs;
  import ppid_pkg::*;
  // Arbitrary values.
  localparam logic [23:0] MAKER = 24'h5A_C301;
  localparam logic [23:0] PROD = 24'h00_7E12;
  localparam logic [63:0] ID_W = {8'h01, 8'h00, MAKER, PROD};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdat = 32'h0, araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, evt_o;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdat, s;
  logic [5:0] tpa = 6'h0, tpb = 6'h0;
  logic [2:0] child = 3'h0, conn = 3'h0, bias = 3'h0, fset = 3'h0, strap = 3'h5;
  logic cvalid = 1'b1;
  logic [8:0] spd = 9'h0;
  logic [2:0] dis_o, conn_o, dis_m, en_m, flt_m;
  logic [7:0] st, rd;
  int errors = 0;
  int checked = 0;
  int seed = 58278;
  always #2.5 clk = ~clk;
  ppid_link_if link_if ();
  ppid_phy_end #(.NUM_PORTS(3), .FILT_CYCLES(3), .MAKER_ID(MAKER), .PRODUCT_IDENTIFIER(PROD))
    i_ppid_phy_end (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .LINK_IF(link_if.phy),
    .TPA_STATE_IN(tpa), .TPB_STATE_IN(tpb), .CHILD_IN(child), .CHILD_VALID_IN(cvalid),
    .CONN_RAW_IN(conn), .BIAS_RAW_IN(bias), .SPEED_IN(spd), .FAULT_SET_IN(fset),
    .DISABLE_STRAP_IN(strap), .PORT_DISABLE_OUT(dis_o), .PORT_CONN_OUT(conn_o),
    .PORT_EVENT_OUT(evt_o));
  ppid_link_end i_ppid_link_end (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .AXI_AWADDR_IN(awaddr),
    .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdat),
    .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
    .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
    .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
    .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
    .AXI_RREADY_IN(rready), .LINK_IF(link_if.link));
  ppid_link_sva i_ppid_link_sva (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .req(link_if.req),
    .wr(link_if.wr), .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack),
    .rdata(link_if.rdata));

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdat <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    d = rdat;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic phy(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    axi_wr(32'h0, {15'h0, w, d, 4'h0, a}, rs);
    do begin
      axi_rd(32'h4, s, rs);
      n++;
    end while (s[0] && n < 20);
    `CHK("link_idle", 1'b0, s[0])
    st = s[7:0];
    q = s[15:8];
  endtask

  function automatic logic [7:0] exp0(input int p);
    return {dis_m[p], bias[p], conn[p], child[p] & cvalid, tpb[2*p+:2], tpa[2*p+:2]};
  endfunction

  function automatic logic [7:0] exp1(input int p);
    return {3'h0, flt_m[p], en_m[p], spd[3*p+:3]};
  endfunction

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    $display("Watchdog expired");
    summarize();
  end

  initial begin
    dis_m = strap;
    en_m = 3'h0;
    flt_m = 3'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("disable_strap", dis_m, dis_o)
    `CHK("conn_reset", 3'h0, conn_o)
    for (int r = 0; r < 6; r++) begin
      @(posedge clk);
      tpa <= 6'($random(seed));
      tpb <= 6'($random(seed));
      child <= 3'($random(seed));
      conn <= 3'($random(seed));
      bias <= 3'($random(seed));
      cvalid <= (r != 2);
      spd <= {3'(r % 3), 3'((r + 1) % 3), 3'((r + 2) % 3)};
      repeat (8) @(posedge clk);
      `CHK("conn_out", conn, conn_o)
      for (int p = 0; p < 3; p++) begin
        phy(1'b1, 4'h7, {4'h0, 4'(p)}, rd);
        phy(1'b0, 4'h8, 8'h00, rd);
        `CHK("port_stat0", exp0(p), rd)
        phy(1'b0, 4'h9, 8'h00, rd);
        `CHK("port_stat1", exp1(p), rd)
        phy(1'b0, 4'(10 + r), 8'h00, rd);
        `CHK("rsvd_rd", 8'h00, rd)
      end
    end
    for (int p = 3; p < 16; p += 12) begin
      phy(1'b1, 4'h7, 8'(p), rd);
      phy(1'b0, 4'h8, 8'h00, rd);
      `CHK("no_port_rd", 8'h00, rd)
    end
    phy(1'b1, 4'h7, 8'h01, rd);
    phy(1'b0, 4'h7, 8'h00, rd);
    `CHK("select_rd", 8'h01, rd)
    phy(1'b1, 4'h8, 8'hFF, rd);
    dis_m[1] = 1'b1;
    `CHK("disable_out", dis_m, dis_o)
    phy(1'b0, 4'h8, 8'h00, rd);
    `CHK("port1_stat0", exp0(1), rd)
    @(posedge clk);
    conn[1] <= ~conn[1];
    @(posedge clk);
    conn[1] <= ~conn[1];
    repeat (6) @(posedge clk);
    `CHK("conn_glitch", conn, conn_o)
    phy(1'b1, 4'h7, 8'h00, rd);
    phy(1'b1, 4'h9, 8'h08, rd);
    en_m[0] = 1'b1;
    @(posedge clk);
    conn[0] <= ~conn[0];
    repeat (8) @(posedge clk);
    `CHK("event_set", 1'b1, evt_o)
    phy(1'b0, 4'h5, 8'h00, rd);
    `CHK("event_rd", 1'b1, rd[2])
    phy(1'b1, 4'h5, 8'h04, rd);
    `CHK("event_clr", 1'b0, evt_o)
    @(posedge clk);
    conn[2] <= ~conn[2];
    repeat (8) @(posedge clk);
    `CHK("event_masked", 1'b0, evt_o)
    @(posedge clk);
    fset[1] <= 1'b1;
    @(posedge clk);
    fset[1] <= 1'b0;
    flt_m[1] = 1'b1;
    phy(1'b1, 4'h7, 8'h01, rd);
    phy(1'b1, 4'h9, 8'h00, rd);
    phy(1'b0, 4'h9, 8'h00, rd);
    `CHK("fault_hold", exp1(1), rd)
    phy(1'b1, 4'h9, 8'h10, rd);
    flt_m[1] = 1'b0;
    phy(1'b0, 4'h9, 8'h00, rd);
    `CHK("fault_clr", exp1(1), rd)
    phy(1'b1, 4'h7, 8'h20, rd);
    phy(1'b1, 4'h8, 8'h55, rd);
    for (int a = 8; a < 16; a++) begin
      phy(1'b0, 4'(a), 8'h00, rd);
      `CHK("ident_byte", ID_W[8*(15-a)+:8], rd)
    end
    phy(1'b1, 4'h7, 8'hE0, rd);
    phy(1'b0, 4'h9, 8'h00, rd);
    `CHK("test_refused", 1'b1, st[1])
    phy(1'b1, 4'h7, 8'h40, rd);
    phy(1'b0, 4'h8, 8'h00, rd);
    `CHK("page2_zero", 8'h00, rd)
    wstrb <= 4'hE;
    phy(1'b1, 4'h7, 8'h00, rd);
    wstrb <= 4'hF;
    phy(1'b0, 4'h8, 8'h00, rd);
    `CHK("strb_ignored", 8'h00, rd)
    axi_wr(32'h0000_0008, 32'h0, rs);
    `CHK("bad_wr_resp", `PPID_RESP_SLVERR, rs)
    axi_rd(32'h0000_0010, s, rs);
    `CHK("bad_rd_resp", `PPID_RESP_SLVERR, rs)
    summarize();
  end
endmodule
